/* File: rtl/gpiu_pkg.sv */
package gpiu_pkg;
    localparam int PORTS = 2;
    localparam int PORT_W = 32;
    localparam int PINS = 64;
    localparam int CHANS = 8;
    localparam int SEL_W = 6;
    localparam int SRC_W = 3;
    localparam int SYNC_STAGES = 2;
    localparam logic [31:0] RST_OUT = 32'h0000_0000;
    localparam logic [31:0] RST_DIR = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'h0000_0000;

    // write operations on one port word
    typedef enum logic [2:0] {
        OP_VALUE = 3'h0,
        OP_SET = 3'h1,
        OP_CLR = 3'h2,
        OP_TOG = 3'h3,
        OP_DIR = 3'h4,
        OP_MASK = 3'h5,
        OP_MPORT = 3'h6,
        OP_NONE = 3'h7
    } gpiu_op_t;

    typedef enum logic [2:0] {
        RD_PIN = 3'h0,
        RD_MPORT = 3'h1,
        RD_DIR = 3'h2,
        RD_OUT = 3'h3,
        RD_MASK = 3'h4,
        RD_RSV5 = 3'h5,
        RD_RSV6 = 3'h6,
        RD_RSV7 = 3'h7
    } gpiu_rd_t;

    // condition of one pattern slice
    typedef enum logic [2:0] {
        PM_ALWAYS = 3'h0,
        PM_STK_RISE = 3'h1,
        PM_STK_FALL = 3'h2,
        PM_STK_ANY = 3'h3,
        PM_LVL_HI = 3'h4,
        PM_LVL_LO = 3'h5,
        PM_NEVER = 3'h6,
        PM_EDGE_NOW = 3'h7
    } gpiu_pm_t;
endpackage : gpiu_pkg

/* File: rtl/gpiu_sync_if.sv */
`timescale 1ns/1ps
interface gpiu_sync_if #(
    parameter int N = gpiu_pkg::PINS
);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : gpiu_sync_if

/* File: rtl/gpiu_sync.sv */
`timescale 1ns/1ps
module gpiu_sync #(
    parameter int N = gpiu_pkg::PINS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [N-1:0] i_pin,
    gpiu_sync_if.src sync_bus
);
    logic [N-1:0] meta;
    logic [N-1:0] stab;
    logic [N-1:0] prev;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta <= '0;
            stab <= '0;
            prev <= '0;
        end else if (i_ce) begin
            meta <= i_pin;
            stab <= meta;
            prev <= stab;
        end
    end

    // edges are taken only between settled stages
    assign sync_bus.lvl = stab;
    assign sync_bus.rise = stab & ~prev;
    assign sync_bus.fall = ~stab & prev;

    sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $past(i_ce) && $past(i_ce, 2) && !$past(i_rst) && !$past(i_rst, 2)
        |-> stab == $past(i_pin, 2))
        else $error("synchronised level does not follow pin by two cycles");
endmodule : gpiu_sync

/* File: rtl/gpiu_top.sv */
`timescale 1ns/1ps
module gpiu_top #(
    parameter int NPORTS = gpiu_pkg::PORTS,
    parameter int CHANS = gpiu_pkg::CHANS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire logic [$clog2(NPORTS)-1:0] i_wr_port,
    input wire gpiu_pkg::gpiu_op_t i_wr_op,
    input wire logic [3:0] i_wr_be,
    input wire logic [31:0] i_wr_data,
    input wire logic [$clog2(NPORTS)-1:0] i_rd_port,
    input wire gpiu_pkg::gpiu_rd_t i_rd_op,
    output logic [31:0] o_rd_data,
    input wire logic [NPORTS*32-1:0] i_pin_in,
    input wire logic [NPORTS*32-1:0] i_periph_own,
    output logic [NPORTS*32-1:0] o_pin_out,
    output logic [NPORTS*32-1:0] o_pin_oe,
    input wire logic i_power_down,
    input wire logic i_deep_power_down,
    input wire logic [CHANS*gpiu_pkg::SEL_W-1:0] i_pint_sel,
    input wire logic [CHANS-1:0] i_pint_level,
    input wire logic [CHANS-1:0] i_pint_rise_en,
    input wire logic [CHANS-1:0] i_pint_fall_en,
    input wire logic [CHANS-1:0] i_pint_clr,
    output logic [CHANS-1:0] o_pint_req,
    input wire logic i_pm_mode,
    input wire logic [CHANS*gpiu_pkg::SRC_W-1:0] i_pm_src,
    input wire logic [CHANS*3-1:0] i_pm_cond,
    input wire logic [CHANS-1:0] i_pm_endpt,
    input wire logic [CHANS-1:0] i_pm_clr,
    input wire logic i_pm_event_en,
    input wire logic i_event_pin_en,
    input wire logic [gpiu_pkg::SEL_W-1:0] i_event_pin_sel,
    output logic o_cpu_event_pulse,
    input wire logic [NPORTS*32-1:0] i_grp0_ena,
    input wire logic [NPORTS*32-1:0] i_grp0_pol,
    input wire logic i_grp0_and,
    input wire logic [NPORTS*32-1:0] i_grp1_ena,
    input wire logic [NPORTS*32-1:0] i_grp1_pol,
    input wire logic i_grp1_and,
    output logic [1:0] o_grp_req
);
    localparam int NP = NPORTS * 32;

    // fixed select and source widths cannot reach other sizes
    if (NPORTS < 2 || NP > gpiu_pkg::PINS || CHANS != gpiu_pkg::CHANS) begin : g_bad_cfg
        $error("gpiu_top: unsupported port or channel count");
    end

    logic [NPORTS-1:0][31:0] out_q;
    logic [NPORTS-1:0][31:0] dir_q;
    logic [NPORTS-1:0][31:0] mask_q;
    logic [CHANS-1:0] edge_flag;
    logic [CHANS-1:0] stk_r;
    logic [CHANS-1:0] stk_f;
    logic any_match_q;
    logic [CHANS-1:0] chan_lvl;
    logic [CHANS-1:0] chan_rise;
    logic [CHANS-1:0] chan_fall;
    logic [CHANS-1:0] term;
    logic [CHANS-1:0] match;
    logic [CHANS-1:0] next_pint;
    logic [31:0] lane;
    logic [NP-1:0] all_out;
    logic [NP-1:0] all_dir;

    gpiu_sync_if #(.N(NP)) sync_bus ();

    gpiu_sync #(.N(NP)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_pin_in),
        .sync_bus(sync_bus)
    );

    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lanes

    function automatic logic pick(input logic [NP-1:0] v, input logic [5:0] idx);
        return (32'(idx) < NP) ? v[idx] : 1'b0;
    endfunction : pick

    assign lane = lanes(i_wr_be);

    // output value register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            out_q <= {NPORTS{gpiu_pkg::RST_OUT}};
        end else if (i_ce && i_wr) begin
            unique case (i_wr_op)
                gpiu_pkg::OP_VALUE: out_q[i_wr_port] <=
                    (out_q[i_wr_port] & ~lane) | (i_wr_data & lane);
                gpiu_pkg::OP_SET: out_q[i_wr_port] <= out_q[i_wr_port] | (i_wr_data & lane);
                gpiu_pkg::OP_CLR: out_q[i_wr_port] <= out_q[i_wr_port] & ~(i_wr_data & lane);
                gpiu_pkg::OP_TOG: out_q[i_wr_port] <= out_q[i_wr_port] ^ (i_wr_data & lane);
                gpiu_pkg::OP_MPORT: out_q[i_wr_port] <= (out_q[i_wr_port]
                    & (mask_q[i_wr_port] | ~lane)) | (i_wr_data & lane & ~mask_q[i_wr_port]);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dir_q <= {NPORTS{gpiu_pkg::RST_DIR}};
        end else if (i_ce && i_wr && i_wr_op == gpiu_pkg::OP_DIR) begin
            dir_q[i_wr_port] <= (dir_q[i_wr_port] & ~lane) | (i_wr_data & lane);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mask_q <= {NPORTS{gpiu_pkg::RST_MASK}};
        end else if (i_ce && i_wr && i_wr_op == gpiu_pkg::OP_MASK) begin
            mask_q[i_wr_port] <= (mask_q[i_wr_port] & ~lane) | (i_wr_data & lane);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rd_data <= '0;
        end else if (i_ce) begin
            unique case (i_rd_op)
                gpiu_pkg::RD_PIN: o_rd_data <= i_pin_in[32*i_rd_port +: 32];
                gpiu_pkg::RD_MPORT: o_rd_data <= i_pin_in[32*i_rd_port +: 32] & ~mask_q[i_rd_port];
                gpiu_pkg::RD_DIR: o_rd_data <= dir_q[i_rd_port];
                gpiu_pkg::RD_OUT: o_rd_data <= out_q[i_rd_port];
                gpiu_pkg::RD_MASK: o_rd_data <= mask_q[i_rd_port];
                default: o_rd_data <= '0;
            endcase
        end
    end

    assign all_out = out_q;
    assign all_dir = dir_q;

    // outside power-down, pins owned by a peripheral are left to it, except the event pin; power-down drives every pin low,
    // deep power-down releases every pin; the event pin overrides gpio and peripheral ownership
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
        end else if (i_ce) begin
            if (i_deep_power_down) begin
                o_pin_out <= '0;
                o_pin_oe <= '0;
            end else if (i_power_down) begin
                o_pin_out <= '0;
                o_pin_oe <= '1;
            end else begin
                o_pin_out <= all_out;
                o_pin_oe <= all_dir & ~i_periph_own;
                if (i_event_pin_en && 32'(i_event_pin_sel) < NP) begin
                    o_pin_out[i_event_pin_sel] <= o_cpu_event_pulse;
                    o_pin_oe[i_event_pin_sel] <= 1'b1;
                end
            end
        end
    end

    // selection from synced pins, any function
    always_comb begin
        for (int c = 0; c < CHANS; c++) begin
            chan_lvl[c] = pick(sync_bus.lvl, i_pint_sel[c*gpiu_pkg::SEL_W +: gpiu_pkg::SEL_W]);
            chan_rise[c] = pick(sync_bus.rise, i_pint_sel[c*gpiu_pkg::SEL_W +: gpiu_pkg::SEL_W]);
            chan_fall[c] = pick(sync_bus.fall, i_pint_sel[c*gpiu_pkg::SEL_W +: gpiu_pkg::SEL_W]);
        end
    end

    // edge flags, set wins over clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            edge_flag <= '0;
        end else if (i_ce) begin
            edge_flag <= (edge_flag & ~i_pint_clr & ~i_pint_level)
                | (~i_pint_level & ((chan_rise & i_pint_rise_en) | (chan_fall & i_pint_fall_en)));
        end
    end

    // pattern sticky edges, set wins over clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stk_r <= '0;
            stk_f <= '0;
        end else if (i_ce) begin
            for (int s = 0; s < CHANS; s++) begin
                stk_r[s] <= (stk_r[s] & ~i_pm_clr[s]) | chan_rise[i_pm_src[s*3 +: 3]];
                stk_f[s] <= (stk_f[s] & ~i_pm_clr[s]) | chan_fall[i_pm_src[s*3 +: 3]];
            end
        end
    end

    always_comb begin
        logic acc;
        logic [2:0] src;
        acc = 1'b1;
        src = '0;
        for (int s = 0; s < CHANS; s++) begin
            src = i_pm_src[s*3 +: 3];
            unique case (gpiu_pkg::gpiu_pm_t'(i_pm_cond[s*3 +: 3]))
                gpiu_pkg::PM_ALWAYS: term[s] = 1'b1;
                gpiu_pkg::PM_STK_RISE: term[s] = stk_r[s];
                gpiu_pkg::PM_STK_FALL: term[s] = stk_f[s];
                gpiu_pkg::PM_STK_ANY: term[s] = stk_r[s] | stk_f[s];
                gpiu_pkg::PM_LVL_HI: term[s] = chan_lvl[src];
                gpiu_pkg::PM_LVL_LO: term[s] = ~chan_lvl[src];
                gpiu_pkg::PM_NEVER: term[s] = 1'b0;
                gpiu_pkg::PM_EDGE_NOW: term[s] = chan_rise[src] | chan_fall[src];
            endcase
            acc = acc & term[s];
            match[s] = acc & i_pm_endpt[s];
            if (i_pm_endpt[s]) begin
                acc = 1'b1;
            end
        end
    end

    // one request per channel; level polarity via fall enable
    always_comb begin
        for (int c = 0; c < CHANS; c++) begin
            next_pint[c] = i_pint_level[c]
                ? (i_pint_rise_en[c] & (chan_lvl[c] ^ i_pint_fall_en[c]))
                : edge_flag[c];
        end
    end

    // settings act on the next edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pint_req <= '0;
        end else if (i_ce) begin
            o_pint_req <= i_pm_mode ? match : next_pint;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            any_match_q <= 1'b0;
            o_cpu_event_pulse <= 1'b0;
        end else if (i_ce) begin
            any_match_q <= i_pm_mode & (|match);
            o_cpu_event_pulse <= i_pm_event_en & i_pm_mode & (|match) & ~any_match_q;
        end
    end

    // group interrupts: or of hits, or and over enabled pins
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_grp_req <= '0;
        end else if (i_ce) begin
            o_grp_req[0] <= i_grp0_and
                ? ((|i_grp0_ena) & (&(~(sync_bus.lvl ^ i_grp0_pol) | ~i_grp0_ena)))
                : (|(~(sync_bus.lvl ^ i_grp0_pol) & i_grp0_ena));
            o_grp_req[1] <= i_grp1_and
                ? ((|i_grp1_ena) & (&(~(sync_bus.lvl ^ i_grp1_pol) | ~i_grp1_ena)))
                : (|(~(sync_bus.lvl ^ i_grp1_pol) & i_grp1_ena));
        end
    end

    default clocking dclk @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    rst_input_a: assert property ($past(i_rst) |-> o_pin_oe == '0)
        else $error("pin driven right after reset");
    set_write_a: assert property (i_ce && i_wr && i_wr_op == gpiu_pkg::OP_SET
        |=> (out_q[$past(i_wr_port)] & $past(i_wr_data & lane)) == $past(i_wr_data & lane))
        else $error("set write did not raise bits");
    tog_write_a: assert property (i_ce && i_wr && i_wr_op == gpiu_pkg::OP_TOG
        |=> out_q[$past(i_wr_port)] == ($past(out_q[i_wr_port]) ^ $past(i_wr_data & lane)))
        else $error("toggle write wrong");
    mask_write_a: assert property (i_ce && i_wr && i_wr_op == gpiu_pkg::OP_MPORT
        |=> (out_q[$past(i_wr_port)] & $past(mask_q[i_wr_port]))
            == $past(out_q[i_wr_port] & mask_q[i_wr_port]))
        else $error("masked write changed masked bits");
    pdown_low_a: assert property (i_ce && i_power_down && !i_deep_power_down
        |=> o_pin_out == '0 && o_pin_oe == '1)
        else $error("pins not low in power-down");
    deep_hiz_a: assert property (i_ce && i_deep_power_down |=> o_pin_oe == '0)
        else $error("pin driven in deep power-down");
    level_req_a: assert property (i_ce && !i_pm_mode && i_pint_level[0]
        && i_pint_rise_en[0] |=> o_pint_req[0] == $past(chan_lvl[0] ^ i_pint_fall_en[0]))
        else $error("level request does not follow pin");
    edge_hold_a: assert property (i_ce && !i_pm_mode && !i_pint_level[0] && edge_flag[0]
        && !i_pint_clr[0] ##1 i_ce && !i_pm_mode && !i_pint_level[0] |=> o_pint_req[0])
        else $error("edge request lost before clear");
    event_pulse_a: assert property (o_cpu_event_pulse && i_ce |=> !o_cpu_event_pulse)
        else $error("cpu event longer than one cycle");
endmodule : gpiu_top

/* File: verification/gpiu_pin_model.sv */
`timescale 1ns/1ps
module gpiu_pin_model #(
    parameter int W = 64
) (
    input wire logic [W-1:0] i_pin_out,
    input wire logic [W-1:0] i_pin_oe,
    input wire logic [W-1:0] i_ext,
    output logic [W-1:0] o_pin_in
);
    // pad level
    // a released pad follows the outside source, never a stale driven level
    assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule : gpiu_pin_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic i_clk_sys = 0, i_rst = 1, i_ce = 1, i_wr = 0, i_wr_port = 0, i_rd_port = 0;
    gpiu_pkg::gpiu_op_t i_wr_op = gpiu_pkg::OP_NONE;
    gpiu_pkg::gpiu_rd_t i_rd_op = gpiu_pkg::RD_PIN;
    logic [3:0] i_wr_be = '0;
    logic [31:0] i_wr_data = '0, o_rd_data;
    logic [63:0] i_pin_in, o_pin_out, o_pin_oe, i_periph_own = '0, ext = '0;
    logic i_power_down = 0, i_deep_power_down = 0, i_pm_mode = 0, i_pm_event_en = 0;
    logic i_event_pin_en = 0, o_cpu_event_pulse, i_grp0_and = 0, i_grp1_and = 0;
    logic [47:0] i_pint_sel = '0;
    logic [7:0] i_pint_level = '0, i_pint_rise_en = '0, i_pint_fall_en = '0, i_pint_clr = '0;
    logic [7:0] o_pint_req, i_pm_endpt = '0, i_pm_clr = '0;
    logic [23:0] i_pm_src = '0, i_pm_cond = '0;
    logic [5:0] i_event_pin_sel = '0;
    logic [63:0] i_grp0_ena = '0, i_grp0_pol = '0, i_grp1_ena = '0, i_grp1_pol = '0;
    logic [1:0] o_grp_req;
    logic [31:0] m_out[2], m_dir[2], m_mask[2];
    logic [31:0] seed = 32'hC102F95F;
    int fail_count = 0, check_count = 0, cyc_n = 0, pidx[8], n, pn;
    logic [31:0] r;
    logic [2:0] ctab[4] = '{3'h0, 3'h4, 3'h5, 3'h6};

    gpiu_top dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_wr(i_wr),
        .i_wr_port(i_wr_port), .i_wr_op(i_wr_op), .i_wr_be(i_wr_be), .i_wr_data(i_wr_data),
        .i_rd_port(i_rd_port), .i_rd_op(i_rd_op), .o_rd_data(o_rd_data),
        .i_pin_in(i_pin_in), .i_periph_own(i_periph_own), .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe), .i_power_down(i_power_down),
        .i_deep_power_down(i_deep_power_down),
        .i_pint_sel(i_pint_sel), .i_pint_level(i_pint_level), .i_pint_rise_en(i_pint_rise_en),
        .i_pint_fall_en(i_pint_fall_en), .i_pint_clr(i_pint_clr), .o_pint_req(o_pint_req),
        .i_pm_mode(i_pm_mode), .i_pm_src(i_pm_src), .i_pm_cond(i_pm_cond),
        .i_pm_endpt(i_pm_endpt), .i_pm_clr(i_pm_clr), .i_pm_event_en(i_pm_event_en),
        .i_event_pin_en(i_event_pin_en), .i_event_pin_sel(i_event_pin_sel),
        .o_cpu_event_pulse(o_cpu_event_pulse), .i_grp0_ena(i_grp0_ena),
        .i_grp0_pol(i_grp0_pol), .i_grp0_and(i_grp0_and), .i_grp1_ena(i_grp1_ena),
        .i_grp1_pol(i_grp1_pol), .i_grp1_and(i_grp1_and), .o_grp_req(o_grp_req)
    );
    gpiu_pin_model #(.W(64)) pins (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext(ext),
        .o_pin_in(i_pin_in));

    initial begin
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // the whole run needs well under two thousand cycles
    always @(posedge i_clk_sys) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic p, input logic [2:0] op, input logic [3:0] be,
        input logic [31:0] d);
        logic [31:0] bm, m;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        m = bm & ~m_mask[p];
        i_wr = 1;
        i_wr_port = p;
        i_wr_op = gpiu_pkg::gpiu_op_t'(op);
        i_wr_be = be;
        i_wr_data = d;
        case (op)
            3'h0: m_out[p] = (m_out[p] & ~bm) | (d & bm);
            3'h1: m_out[p] |= d & bm;
            3'h2: m_out[p] &= ~(d & bm);
            3'h3: m_out[p] ^= d & bm;
            3'h4: m_dir[p] = (m_dir[p] & ~bm) | (d & bm);
            3'h5: m_mask[p] = (m_mask[p] & ~bm) | (d & bm);
            3'h6: m_out[p] = (m_out[p] & ~m) | (d & m);
            default: ;
        endcase
        // strobe stays up so that a following call writes on the very next edge
        cyc(1);
    endtask : wr

    function automatic logic [31:0] rexp(input logic p, input int k);
        logic [31:0] oe, pin;
        oe = m_dir[p] & ~i_periph_own[p*32+:32];
        pin = (oe & m_out[p]) | (~oe & ext[p*32+:32]);
        case (k)
            0: return pin;
            1: return pin & ~m_mask[p];
            2: return m_dir[p];
            3: return m_out[p];
            4: return m_mask[p];
            default: return '0;
        endcase
    endfunction : rexp

    task automatic setch(input logic [7:0] v);
        for (int c = 0; c < 8; c++)
            ext[pidx[c]] = v[c];
    endtask : setch

    task automatic clr_flags();
        i_pint_clr = '1;
        cyc(1);
        i_pint_clr = '0;
        cyc(2);
    endtask : clr_flags

    function automatic logic [7:0] pmexp(input logic [7:0] v);
        logic [7:0] e;
        logic prod, lv, t;
        e = '0;
        prod = 1;
        for (int s = 0; s < 8; s++) begin
            lv = v[i_pm_src[3*s+:3]];
            case (i_pm_cond[3*s+:3])
                3'h0: t = 1;
                3'h4: t = lv;
                3'h5: t = ~lv;
                default: t = 0;
            endcase
            prod &= t;
            if (i_pm_endpt[s]) begin
                e[s] = prod;
                prod = 1;
            end
        end
        return e;
    endfunction : pmexp

    function automatic logic gexp(input logic [63:0] en, input logic [63:0] pol, input logic a);
        logic [63:0] hit;
        hit = en & ~(ext ^ pol);
        return a ? (en != 0 && hit == en) : (hit != 0);
    endfunction : gexp

    initial begin
        for (int p = 0; p < 2; p++) begin
            m_out[p] = gpiu_pkg::RST_OUT;
            m_dir[p] = gpiu_pkg::RST_DIR;
            m_mask[p] = gpiu_pkg::RST_MASK;
        end
        cyc(5);
        i_rst = 0;
        chk(o_pin_oe, '0);
        chk({o_pint_req, o_grp_req, o_cpu_event_pulse, o_rd_data}, '0);
        for (int i = 0; i < 64; i++) begin
            r = rnd();
            ext = {rnd(), rnd()};
            i_periph_own = {rnd() & rnd(), rnd() & rnd()};
            wr(r[0], i[2:0], r[7:4], rnd());
            if (r[8])
                wr(r[9], r[12:10], 4'hF, rnd());
            i_wr = 0;
            cyc(1);
            for (int k = 0; k < 8; k++) begin
                i_rd_port = r[13];
                i_rd_op = gpiu_pkg::gpiu_rd_t'(k[2:0]);
                cyc(1);
                chk(o_rd_data, rexp(r[13], k));
            end
            chk(o_pin_oe, {m_dir[1], m_dir[0]} & ~i_periph_own);
            chk(o_pin_out & o_pin_oe, {m_out[1], m_out[0]} & {m_dir[1], m_dir[0]} &
                ~i_periph_own);
        end
        // a write while the clock enable is low must leave no trace
        i_ce = 0;
        i_wr = 1;
        i_wr_port = 0;
        i_wr_op = gpiu_pkg::OP_TOG;
        i_wr_be = 4'hF;
        i_wr_data = '1;
        i_rd_port = 0;
        i_rd_op = gpiu_pkg::RD_OUT;
        cyc(2);
        i_wr = 0;
        i_ce = 1;
        cyc(1);
        chk(o_rd_data, m_out[0]);
        $display("port register test done");
        i_power_down = 1;
        cyc(2);
        chk({o_pin_out, o_pin_oe}, {64'h0, {64{1'b1}}});
        i_deep_power_down = 1;
        cyc(2);
        chk({o_pin_out, o_pin_oe}, '0);
        i_power_down = 0;
        i_deep_power_down = 0;
        $display("power-down test done");
        wr(0, 3'h4, 4'hF, '0);
        wr(1, 3'h4, 4'hF, '0);
        i_wr = 0;
        // peripheral ownership must not hide pins from the interrupt engine
        i_periph_own = '1;
        for (int c = 0; c < 8; c++) begin
            pidx[c] = 8 * c + int'(rnd() % 8);
            i_pint_sel[6*c+:6] = pidx[c][5:0];
        end
        setch('0);
        cyc(6);
        for (int k = 0; k < 4; k++) begin
            i_pint_rise_en = 8'(rnd());
            i_pint_fall_en = 8'(rnd());
            clr_flags();
            setch({8{~k[0]}});
            cyc(3);
            chk(o_pint_req, '0);
            cyc(1);
            chk(o_pint_req, k[0] ? i_pint_fall_en : i_pint_rise_en);
        end
        i_pint_level = '1;
        for (int k = 0; k < 6; k++) begin
            i_pint_rise_en = 8'(rnd());
            i_pint_fall_en = 8'(rnd());
            r = rnd();
            setch(r[7:0]);
            cyc(3);
            chk(o_pint_req, i_pint_rise_en & (r[7:0] ^ i_pint_fall_en));
        end
        $display("pin interrupt test done");
        i_pm_mode = 1;
        for (int k = 0; k < 12; k++) begin
            i_pm_src = 24'(rnd());
            for (int s = 0; s < 8; s++)
                i_pm_cond[3*s+:3] = ctab[rnd() % 4];
            i_pm_endpt = 8'(rnd()) | 8'h80;
            r = rnd();
            setch(r[7:0]);
            cyc(5);
            chk(o_pint_req, pmexp(r[7:0]));
        end
        // sticky transitions: rise then fall on channel 0, then cleared
        i_pm_src = '0;
        i_pm_cond = 24'h000011;
        i_pm_endpt = 8'h03;
        setch('0);
        cyc(4);
        i_pm_clr = '1;
        cyc(1);
        i_pm_clr = '0;
        setch(8'h01);
        cyc(5);
        chk(o_pint_req, 8'h01);
        setch('0);
        cyc(5);
        chk(o_pint_req, 8'h03);
        i_pm_clr = '1;
        cyc(2);
        i_pm_clr = '0;
        chk(o_pint_req, 8'h00);
        i_pm_src = '0;
        i_pm_cond = {8{3'h4}};
        i_pm_endpt = '1;
        i_pm_event_en = 1;
        i_event_pin_en = 1;
        // event pin kept off every channel pin so the pulse cannot feed back
        i_event_pin_sel = 6'(pidx[7] ^ 1);
        setch('0);
        cyc(5);
        setch(8'h01);
        n = 0;
        pn = 0;
        repeat (10) begin
            cyc(1);
            n += int'(o_cpu_event_pulse === 1'b1);
            pn += int'(o_pin_out[i_event_pin_sel] === 1'b1);
        end
        chk(n, 1);
        chk(pn, 1);
        chk(o_pin_oe[i_event_pin_sel], 1'b1);
        i_event_pin_en = 0;
        $display("pattern test done");
        for (int k = 0; k < 8; k++) begin
            ext = {rnd(), rnd()};
            i_grp0_ena = {rnd(), rnd()} & {rnd(), rnd()};
            i_grp1_ena = {rnd(), rnd()} & {rnd(), rnd()};
            i_grp0_pol = k[1] ? ext : {rnd(), rnd()};
            i_grp1_pol = k[1] ? ext : ~ext;
            i_grp0_and = k[0];
            i_grp1_and = ~k[0];
            cyc(4);
            chk(o_grp_req, {gexp(i_grp1_ena, i_grp1_pol, i_grp1_and),
                gexp(i_grp0_ena, i_grp0_pol, i_grp0_and)});
        end
        $display("group test done");
        stop_test();
    end
endmodule : testbench
